// file: core/isq_pkg.sv
// Constants, types and register map of the two-wire bus controller
package isq_pkg;
	// Register indices; byte address is four times the index
	localparam logic [9:0] CTL_IDX  = 10'h0c0;
	localparam logic [9:0] STAT_IDX = 10'h0bd;
	localparam logic [9:0] DATA_IDX = 10'h0c4;
	localparam logic [9:0] RATE_IDX = 10'h0c8;
	localparam logic [9:0] IST_IDX  = 10'h0cc;
	localparam logic [9:0] IMSK_IDX = 10'h0ce;
	localparam int EN_BIT  = 6;
	localparam int STA_BIT = 5;
	localparam int STO_BIT = 4;
	localparam int SI_BIT  = 3;
	localparam int AA_BIT  = 2;
	localparam int PX_BIT  = 0;
	localparam logic [7:0] CTL_RESET  = 8'h00;
	localparam logic [7:0] RATE_RESET = 8'h10;
	// Interrupt status bits
	localparam int IRQ_SI   = 0;
	localparam int IRQ_ARB  = 1;
	localparam int IRQ_ERR  = 2;
	localparam int IRQ_STOP = 3;
	// State codes
	localparam logic [7:0] ST_IDLE   = 8'hf8;
	localparam logic [7:0] ST_BERR   = 8'h00;
	localparam logic [7:0] ST_START  = 8'h08;
	localparam logic [7:0] ST_RSTART = 8'h10;
	localparam logic [7:0] ST_AW_ACK = 8'h18;
	localparam logic [7:0] ST_AW_NAK = 8'h20;
	localparam logic [7:0] ST_TX_ACK = 8'h28;
	localparam logic [7:0] ST_TX_NAK = 8'h30;
	localparam logic [7:0] ST_ARB    = 8'h38;
	localparam logic [7:0] ST_AR_ACK = 8'h40;
	localparam logic [7:0] ST_AR_NAK = 8'h48;
	localparam logic [7:0] ST_RX_ACK = 8'h50;
	localparam logic [7:0] ST_RX_NAK = 8'h58;

	typedef enum logic [4:0] {
		S_IDLE  = 5'b00001,
		S_START = 5'b00010,
		S_WAIT  = 5'b00100,
		S_BIT   = 5'b01000,
		S_STOP  = 5'b10000
	} isq_state_e;

	typedef struct packed {
		isq_state_e state;
		logic [1:0] q;
		logic [3:0] bitn;
		logic [7:0] shift;
		logic       master;
		logic       rx;
		logic       restart;
		logic       bytes;
		logic       ackn;
		logic [7:0] status;
		logic       scl_drv;
		logic       sda_drv;
		logic       busy;
		logic [7:0] div;
	} isq_core_s;
endpackage

// file: core/isq_ctrl.sv
// Two-wire bus controller with APB register access
`timescale 1ns/1ps
`default_nettype none
module isq_ctrl (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [31:0] pwdata_i,
	output logic             pready_o,
	output logic      [31:0] prdata_o,
	output logic             pslverr_o,
	input  wire logic  [1:0] scl_pin_i,
	input  wire logic  [1:0] sda_pin_i,
	output logic       [1:0] scl_o,
	output logic       [1:0] sda_o,
	output logic       [1:0] scl_oe_o,
	output logic       [1:0] sda_oe_o,
	output logic             irq_o
);
	////////////////////////////////////////////////////////////////////////
	function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
		hit = (a == {idx, 2'b00});
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers, both pairs always sampled
	logic [3:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
	logic [1:0] prev_reg, prev_next;
	logic       sclv, sdav;
	logic [7:0] ctl_reg, ctl_next;

	always_comb begin
		sync1_next = {sda_pin_i, scl_pin_i};
		sync2_next = sync1_reg;
		sclv       = sync2_reg[{1'b0, ctl_reg[isq_pkg::PX_BIT]}];
		sdav       = sync2_reg[{1'b1, ctl_reg[isq_pkg::PX_BIT]}];
		prev_next  = {sdav, sclv};
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync1_reg <= 4'hf;
			sync2_reg <= 4'hf;
			prev_reg  <= 2'h3;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			prev_reg  <= prev_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Engine and register file
	isq_pkg::isq_core_s core_reg, core_next;
	logic [7:0]  data_reg, data_next, rate_reg, rate_next;
	logic [3:0]  ist_reg, ist_next, imsk_reg, imsk_next;
	logic        pready_next, pslverr_next, irq_next;
	logic [31:0] prdata_next;
	logic [1:0]  scl_oe_next, sda_oe_next;
	logic        en, start_det, stop_det, tick, adv, enter, wr, rd_cap;
	logic        ev_arb, ev_err;
	logic [7:0]  code;

	always_comb begin
		core_next    = core_reg;
		ctl_next     = ctl_reg;
		data_next    = data_reg;
		rate_next    = rate_reg;
		ist_next     = ist_reg;
		imsk_next    = imsk_reg;
		prdata_next  = prdata_o;
		pslverr_next = pslverr_o;
		enter        = 1'b0;
		code         = isq_pkg::ST_IDLE;
		ev_arb       = 1'b0;
		ev_err       = 1'b0;
		en           = ctl_reg[isq_pkg::EN_BIT];
		start_det    = prev_reg[1] & !sdav & sclv & prev_reg[0];
		stop_det     = !prev_reg[1] & sdav & sclv & prev_reg[0];
		tick         = (core_reg.div == rate_reg);
		// Clock stretching: a released line still low stalls the phase
		adv          = tick & (core_reg.scl_drv | sclv);
		core_next.div = tick ? 8'h00 : core_reg.div + 8'h01;

		if (start_det)
			core_next.busy = 1'b1;
		if (stop_det) begin
			core_next.busy = 1'b0;
			ctl_next[isq_pkg::STO_BIT] = 1'b0;
		end

		case (core_reg.state)
		isq_pkg::S_IDLE: begin
			core_next.scl_drv = 1'b0;
			core_next.sda_drv = 1'b0;
			// Busy bus holds the request until the stop is seen
			if (adv && ctl_reg[isq_pkg::STA_BIT] && !ctl_reg[isq_pkg::SI_BIT]
			    && !core_reg.busy) begin
				core_next.state   = isq_pkg::S_START;
				core_next.q       = 2'd0;
				core_next.restart = 1'b0;
				core_next.bytes   = 1'b0;
			end
		end
		isq_pkg::S_START: if (adv) begin
			core_next.q = core_reg.q + 2'd1;
			case (core_reg.q)
			2'd0: core_next.sda_drv = 1'b0;
			2'd1: core_next.scl_drv = 1'b0;
			2'd2: core_next.sda_drv = 1'b1;
			default: begin
				core_next.scl_drv = 1'b1;
				enter = 1'b1;
				code  = core_reg.bytes ? isq_pkg::ST_RSTART : isq_pkg::ST_START;
				core_next.master = 1'b1;
				core_next.bytes  = 1'b0;
				core_next.rx     = 1'b0;
				core_next.state  = isq_pkg::S_WAIT;
			end
			endcase
		end
		isq_pkg::S_WAIT: begin
			core_next.scl_drv = core_reg.master;
			if (adv && !ctl_reg[isq_pkg::SI_BIT]) begin
				core_next.q = 2'd0;
				if (!core_reg.master)
					core_next.state = isq_pkg::S_IDLE;
				else if (ctl_reg[isq_pkg::STO_BIT]) begin
					core_next.state   = isq_pkg::S_STOP;
					core_next.restart = ctl_reg[isq_pkg::STA_BIT];
				end else if (ctl_reg[isq_pkg::STA_BIT]) begin
					core_next.state = isq_pkg::S_START;
					core_next.bytes = core_reg.bytes;
				end else begin
					core_next.state = isq_pkg::S_BIT;
					core_next.bitn  = 4'd0;
					core_next.shift = core_reg.rx ? 8'hff : data_reg;
				end
			end
		end
		isq_pkg::S_BIT: if (adv) begin
			core_next.q = core_reg.q + 2'd1;
			case (core_reg.q)
			2'd0: core_next.sda_drv = core_reg.bitn[3] ?
				(core_reg.rx & ctl_reg[isq_pkg::AA_BIT]) :
				(!core_reg.rx & !core_reg.shift[7]);
			2'd1: core_next.scl_drv = 1'b0;
			2'd2: begin
				if (core_reg.bitn[3])
					core_next.ackn = sdav;
				else begin
					core_next.shift = {core_reg.shift[6:0], sdav};
					// Lost arbitration: sent high, read low
					if (!core_reg.rx && !core_reg.sda_drv && !sdav) begin
						core_next.master  = 1'b0;
						core_next.sda_drv = 1'b0;
						core_next.state   = isq_pkg::S_WAIT;
						enter  = 1'b1;
						code   = isq_pkg::ST_ARB;
						ev_arb = 1'b1;
					end
				end
			end
			default: begin
				core_next.scl_drv = 1'b1;
				core_next.bitn    = core_reg.bitn + 4'd1;
				if (core_reg.bitn[3]) begin
					core_next.sda_drv = 1'b0;
					core_next.state   = isq_pkg::S_WAIT;
					core_next.bytes   = 1'b1;
					enter = 1'b1;
					if (!core_reg.bytes) begin
						core_next.rx = data_reg[0] & !core_reg.ackn;
						if (data_reg[0])
							code = core_reg.ackn ? isq_pkg::ST_AR_NAK : isq_pkg::ST_AR_ACK;
						else
							code = core_reg.ackn ? isq_pkg::ST_AW_NAK : isq_pkg::ST_AW_ACK;
					end else if (core_reg.rx) begin
						data_next = core_reg.shift;
						code = ctl_reg[isq_pkg::AA_BIT] ? isq_pkg::ST_RX_ACK : isq_pkg::ST_RX_NAK;
					end else
						code = core_reg.ackn ? isq_pkg::ST_TX_NAK : isq_pkg::ST_TX_ACK;
				end
			end
			endcase
		end
		isq_pkg::S_STOP: if (adv) begin
			core_next.q = core_reg.q + 2'd1;
			case (core_reg.q)
			2'd0: core_next.sda_drv = 1'b1;
			2'd1: core_next.scl_drv = 1'b0;
			2'd2: core_next.sda_drv = 1'b0;
			default: begin
				core_next.master = 1'b0;
				core_next.status = isq_pkg::ST_IDLE;
				core_next.bytes  = 1'b0;
				core_next.state  = core_reg.restart ? isq_pkg::S_START : isq_pkg::S_IDLE;
			end
			endcase
		end
		default: core_next.state = isq_pkg::S_IDLE;
		endcase

		// Foreign start or stop in mid-byte is a bus error
		if ((start_det || stop_det) && core_reg.state == isq_pkg::S_BIT) begin
			core_next.master  = 1'b0;
			core_next.scl_drv = 1'b0;
			core_next.sda_drv = 1'b0;
			core_next.state   = isq_pkg::S_WAIT;
			enter  = 1'b1;
			code   = isq_pkg::ST_BERR;
			ev_err = 1'b1;
		end
		if (core_reg.status == isq_pkg::ST_BERR && ctl_reg[isq_pkg::STO_BIT]) begin
			ctl_next[isq_pkg::STO_BIT] = 1'b0;
			core_next.status = isq_pkg::ST_IDLE;
			core_next.state  = isq_pkg::S_IDLE;
		end

		// APB: access phase takes two cycles, data registered
		wr     = psel_i & penable_i & pready_o & pwrite_i;
		rd_cap = psel_i & penable_i & !pready_o;
		pready_next = rd_cap;
		if (rd_cap) begin
			pslverr_next = 1'b0;
			prdata_next  = 32'h0000_0000;
			if (hit(paddr_i, isq_pkg::CTL_IDX))
				prdata_next[7:0] = {1'b0, ctl_reg[6:2], 1'b0, ctl_reg[0]};
			else if (hit(paddr_i, isq_pkg::STAT_IDX))
				prdata_next[7:0] = {core_reg.status[7:3], 3'b000};
			else if (hit(paddr_i, isq_pkg::DATA_IDX))
				prdata_next[7:0] = data_reg;
			else if (hit(paddr_i, isq_pkg::RATE_IDX))
				prdata_next[7:0] = rate_reg;
			else if (hit(paddr_i, isq_pkg::IST_IDX))
				prdata_next[3:0] = ist_reg;
			else if (hit(paddr_i, isq_pkg::IMSK_IDX))
				prdata_next[3:0] = imsk_reg;
			else
				pslverr_next = 1'b1;
		end
		// W1C on interrupt status first, so a same-cycle event survives
		if (wr && hit(paddr_i, isq_pkg::IST_IDX))
			ist_next = ist_reg & ~pwdata_i[3:0];
		if (wr && hit(paddr_i, isq_pkg::IMSK_IDX))
			imsk_next = pwdata_i[3:0];
		if (wr && hit(paddr_i, isq_pkg::DATA_IDX))
			data_next = pwdata_i[7:0];
		if (wr && hit(paddr_i, isq_pkg::RATE_IDX))
			rate_next = pwdata_i[7:0];
		if (wr && hit(paddr_i, isq_pkg::CTL_IDX)) begin
			ctl_next[isq_pkg::EN_BIT]  = pwdata_i[isq_pkg::EN_BIT];
			ctl_next[isq_pkg::STA_BIT] = pwdata_i[isq_pkg::STA_BIT];
			ctl_next[isq_pkg::STO_BIT] = pwdata_i[isq_pkg::STO_BIT];
			ctl_next[isq_pkg::AA_BIT]  = pwdata_i[isq_pkg::AA_BIT];
			ctl_next[isq_pkg::PX_BIT]  = pwdata_i[isq_pkg::PX_BIT];
			// Software may only clear the flag
			ctl_next[isq_pkg::SI_BIT] = ctl_reg[isq_pkg::SI_BIT] & pwdata_i[isq_pkg::SI_BIT];
		end
		if (enter) begin
			core_next.status = code;
			if (code != isq_pkg::ST_IDLE) begin
				ctl_next[isq_pkg::SI_BIT] = 1'b1;
				ist_next[isq_pkg::IRQ_SI] = 1'b1;
			end
		end
		if (ev_arb)
			ist_next[isq_pkg::IRQ_ARB] = 1'b1;
		if (ev_err)
			ist_next[isq_pkg::IRQ_ERR] = 1'b1;
		if (stop_det && en)
			ist_next[isq_pkg::IRQ_STOP] = 1'b1;

		// Disabled: engine parked, lines released, bus ignored
		if (!en) begin
			core_next = '0;
			core_next.state  = isq_pkg::S_IDLE;
			core_next.status = isq_pkg::ST_IDLE;
			if (!(wr && hit(paddr_i, isq_pkg::CTL_IDX)))
				ctl_next[isq_pkg::STO_BIT] = ctl_reg[isq_pkg::STO_BIT];
		end
		irq_next    = |(ist_next & imsk_next);
		scl_oe_next = ctl_next[isq_pkg::PX_BIT] ? {core_next.scl_drv, 1'b0} : {1'b0, core_next.scl_drv};
		sda_oe_next = ctl_next[isq_pkg::PX_BIT] ? {core_next.sda_drv, 1'b0} : {1'b0, core_next.sda_drv};
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			core_reg        <= '0;
			core_reg.state  <= isq_pkg::S_IDLE;
			core_reg.status <= isq_pkg::ST_IDLE;
			ctl_reg   <= isq_pkg::CTL_RESET;
			data_reg  <= 8'h00;
			rate_reg  <= isq_pkg::RATE_RESET;
			ist_reg   <= 4'h0;
			imsk_reg  <= 4'h0;
			pready_o  <= 1'b0;
			prdata_o  <= 32'h0000_0000;
			pslverr_o <= 1'b0;
			irq_o     <= 1'b0;
			scl_oe_o  <= 2'h0;
			sda_oe_o  <= 2'h0;
			scl_o     <= 2'h0;
			sda_o     <= 2'h0;
		end else begin
			core_reg  <= core_next;
			ctl_reg   <= ctl_next;
			data_reg  <= data_next;
			rate_reg  <= rate_next;
			ist_reg   <= ist_next;
			imsk_reg  <= imsk_next;
			pready_o  <= pready_next;
			prdata_o  <= prdata_next;
			pslverr_o <= pslverr_next;
			irq_o     <= irq_next;
			scl_oe_o  <= scl_oe_next;
			sda_oe_o  <= sda_oe_next;
			// Open drain: only ever pulls low
			scl_o     <= 2'h0;
			sda_o     <= 2'h0;
		end
	end
endmodule
`default_nettype wire

// file: tb/isq_ctrl_props.sv
// Port checker for the two-wire bus controller
`timescale 1ns/1ps
`default_nettype none
module isq_ctrl_props (
	input wire logic        clk_i,
	input wire logic        reset_n_i,
	input wire logic [11:0] paddr_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [31:0] pwdata_i,
	input wire logic        pready_o,
	input wire logic [31:0] prdata_o,
	input wire logic        pslverr_o,
	input wire logic [1:0]  scl_pin_i,
	input wire logic [1:0]  sda_pin_i,
	input wire logic [1:0]  scl_o,
	input wire logic [1:0]  sda_o,
	input wire logic [1:0]  scl_oe_o,
	input wire logic [1:0]  sda_oe_o,
	input wire logic        irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	logic en_reg;
	logic px_reg;
	logic wr;
	assign wr = pready_o && pwrite_i;
	// Shadow of enable and pin pair, taken at the write edge
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			en_reg <= 1'h0;
			px_reg <= 1'h0;
		end else if (wr && paddr_i == 12'h300) begin
			en_reg <= pwdata_i[isq_pkg::EN_BIT];
			px_reg <= pwdata_i[isq_pkg::PX_BIT];
		end
	end
	////////////////////////////////////////////////////////////////
	off_quiet_a: assert property ((!en_reg) [*2] |-> !(scl_oe_o || sda_oe_o))
		else $error("bus pulled while disabled");
	pair_only_a: assert property ($stable(px_reg) |-> !scl_oe_o[!px_reg] && !sda_oe_o[!px_reg])
		else $error("unselected pair pulled");
	stat_low_a: assert property (pready_o && !pwrite_i && paddr_i == 12'h2f4
		|-> (prdata_o & 32'hffffff07) == 32'h0)
		else $error("status low bits set");
	irq_fall_a: assert property ($fell(irq_o) |-> $past(wr) || $past(wr, 2))
		else $error("irq fell without a write");
	start_clk_a: assert property ($rose(sda_oe_o[px_reg]) && scl_pin_i[px_reg]
		|-> ##[1:600] scl_oe_o[px_reg])
		else $error("start not followed by clock");
	rdy_pulse_a: assert property (pready_o |=> !pready_o)
		else $error("ready held");
	rdy_wait_a: assert property ($rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
		else $error("ready timing");
	bad_addr_a: assert property (pready_o && paddr_i == 12'hffc |-> pslverr_o)
		else $error("no error on unmapped");
	open_drain_a: assert property (scl_o == 2'h0 && sda_o == 2'h0)
		else $error("line driven high");
	start_c: cover property ($rose(sda_oe_o[px_reg]) && scl_pin_i[px_reg]);
	irq_c: cover property ($rose(irq_o));
	err_c: cover property (pready_o && pslverr_o);
endmodule
bind isq_ctrl isq_ctrl_props i_isq_ctrl_props (.clk_i, .reset_n_i, .paddr_i, .psel_i, .penable_i, .pwrite_i,
	.pwdata_i, .pready_o, .prdata_o, .pslverr_o, .scl_pin_i, .sda_pin_i, .scl_o, .sda_o, .scl_oe_o, .sda_oe_o, .irq_o);
`default_nettype wire

// file: tb/isq_bus_model.sv
// Slave on the two-wire bus: acks every byte, may stretch the clock
`timescale 1ns/1ps
`default_nettype none
module isq_bus_model (
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	input  wire logic stretch_i,
	output logic      scl_pull_o,
	output logic      sda_pull_o
);
	logic [3:0] cnt;
	logic [3:0] hold;
	logic       scl_q;
	logic       sda_q;
	// Bounded stretch at byte start, so a stuck model cannot hang the bus
	assign scl_pull_o = stretch_i && cnt == 4'h0 && hold != 4'hf;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt        <= 4'hf;
			hold       <= 4'h0;
			scl_q      <= 1'h1;
			sda_q      <= 1'h1;
			sda_pull_o <= 1'h0;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
			hold  <= (scl_q && !scl_i) ? 4'h0 : hold + {3'h0, scl_pull_o};
			if (scl_i && sda_q && !sda_i)
				cnt <= 4'hf;
			else if (scl_q && !scl_i) begin
				cnt        <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
				sda_pull_o <= cnt == 4'h7;
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/isq_ctrl_test.sv
// Self-checking bench for the two-wire bus controller
`timescale 1ns/1ps
`default_nettype none
module isq_ctrl_test;
	localparam logic [11:0] A_CTL  = {isq_pkg::CTL_IDX, 2'h0};
	localparam logic [11:0] A_STAT = {isq_pkg::STAT_IDX, 2'h0};
	localparam logic [11:0] A_DATA = {isq_pkg::DATA_IDX, 2'h0};
	localparam logic [11:0] A_RATE = {isq_pkg::RATE_IDX, 2'h0};
	localparam logic [11:0] A_IST  = {isq_pkg::IST_IDX, 2'h0};
	localparam logic [11:0] A_IMSK = {isq_pkg::IMSK_IDX, 2'h0};
	// Row: address, write, data, expected read, expected error
	localparam logic [29:0] ROWS [10] = '{{A_CTL, 1'h0, 8'h0, 8'h00, 1'h0}, {A_STAT, 1'h0, 8'h0, 8'hf8, 1'h0},
		{A_RATE, 1'h0, 8'h0, 8'h10, 1'h0}, {A_RATE, 1'h1, 8'h01, 8'h0, 1'h0}, {A_CTL, 1'h1, 8'h8a, 8'h0, 1'h0},
		{A_CTL, 1'h0, 8'h0, 8'h00, 1'h0}, {A_IMSK, 1'h1, 8'h01, 8'h0, 1'h0}, {A_IMSK, 1'h0, 8'h0, 8'h01, 1'h0},
		{A_IST, 1'h0, 8'h0, 8'h00, 1'h0}, {12'hffc, 1'h1, 8'hff, 8'h0, 1'h1}};
	logic        clk_i;
	logic        reset_n_i;
	logic [11:0] paddr_i;
	logic        psel_i;
	logic        penable_i;
	logic        pwrite_i;
	logic [31:0] pwdata_i;
	logic        pready_o;
	logic [31:0] prdata_o;
	logic        pslverr_o;
	logic [1:0]  scl_pin_i;
	logic [1:0]  sda_pin_i;
	logic [1:0]  scl_oe_o;
	logic [1:0]  sda_oe_o;
	logic [1:0]  tb_scl;
	logic [1:0]  tb_sda;
	logic        irq_o;
	logic        sel;
	logic        stretch;
	logic        m_scl;
	logic        m_sda;
	logic [31:0] rdat;
	logic        rerr;
	int          stops;
	int          mismatches;
	int          tests_run;
	// Pull-ups on every line; anyone may pull low
	assign scl_pin_i = ~(scl_oe_o | tb_scl | ({1'h0, m_scl} << sel));
	assign sda_pin_i = ~(sda_oe_o | tb_sda | ({1'h0, m_sda} << sel));
	isq_ctrl i_isq_ctrl (.clk_i, .reset_n_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i, .pready_o,
		.prdata_o, .pslverr_o, .scl_pin_i, .sda_pin_i, .scl_o(), .sda_o(), .scl_oe_o, .sda_oe_o, .irq_o);
	isq_bus_model i_isq_bus_model (.clk_i, .reset_n_i, .scl_i(scl_pin_i[sel]), .sda_i(sda_pin_i[sel]),
		.stretch_i(stretch), .scl_pull_o(m_scl), .sda_pull_o(m_sda));
	initial begin
		clk_i = 1'h0;
		forever #2 clk_i = ~clk_i;
	end
	always @(posedge sda_pin_i[sel])
		if (scl_pin_i[sel])
			stops++;
	////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bound(input int n);
		if (n >= 4000) begin
			chk(32'h0, 32'h1);
			end_sim();
		end
	endtask
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		psel_i   <= 1'h1;
		paddr_i  <= a;
		pwrite_i <= w;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'h1 && n < 4000);
		bound(n);
		rdat = prdata_o;
		rerr = pslverr_o;
		psel_i    <= 1'h0;
		penable_i <= 1'h0;
	endtask
	task automatic awaitf(input logic [7:0] st);
		int n;
		n = 0;
		while (irq_o !== 1'h1 && n < 4000) begin
			@(negedge clk_i);
			n++;
		end
		bound(n);
		apb(A_STAT, 1'h0, 32'h0);
		chk(rdat, {24'h0, st});
	endtask
	task automatic step(input logic [7:0] c, input logic [7:0] st);
		apb(A_IST, 1'h1, 32'h1);
		apb(A_CTL, 1'h1, {24'h0, c});
		awaitf(st);
	endtask
	task automatic stop_bus(input logic p);
		int n;
		int s;
		s = stops;
		apb(A_IST, 1'h1, 32'h1);
		apb(A_CTL, 1'h1, {24'h0, 7'h2a, p});
		n = 0;
		do begin
			apb(A_CTL, 1'h0, 32'h0);
			n++;
		end while (rdat[4] !== 1'h0 && n < 4000);
		bound(n);
		chk(rdat, {24'h0, 7'h22, p});
		chk(32'(stops - s), 32'h1);
		apb(A_STAT, 1'h0, 32'h0);
		chk(rdat, 32'hf8);
		chk({31'h0, irq_o}, 32'h0);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		int s;
		int n;
		reset_n_i = 1'h0;
		psel_i = 1'h0;
		penable_i = 1'h0;
		pwrite_i = 1'h0;
		paddr_i = 12'h0;
		pwdata_i = 32'h0;
		tb_scl = 2'h0;
		tb_sda = 2'h0;
		sel = 1'h0;
		stretch = 1'h0;
		stops = 0;
		mismatches = 0;
		tests_run = 0;
		repeat (12) @(posedge clk_i);
		reset_n_i <= 1'h1;
		foreach (ROWS[i]) begin
			apb(ROWS[i][29:18], ROWS[i][17], {24'h0, ROWS[i][16:9]});
			if (!ROWS[i][17])
				chk(rdat, {24'h0, ROWS[i][8:1]});
			chk({31'h0, rerr}, {31'h0, ROWS[i][0]});
		end
		apb(A_CTL, 1'h1, 32'h20);
		repeat (200) @(negedge clk_i);
		chk({29'h0, scl_oe_o, irq_o}, 32'h0);
		apb(A_DATA, 1'h1, 32'ha4);
		step(8'h64, isq_pkg::ST_START);
		repeat (100) @(negedge clk_i);
		chk({30'h0, scl_oe_o}, 32'h1);
		apb(A_CTL, 1'h0, 32'h0);
		chk(rdat, 32'h6c);
		apb(A_IMSK, 1'h1, 32'h0);
		repeat (3) @(negedge clk_i);
		chk({31'h0, irq_o}, 32'h0);
		apb(A_IMSK, 1'h1, 32'h1);
		repeat (3) @(negedge clk_i);
		chk({31'h0, irq_o}, 32'h1);
		step(8'h44, isq_pkg::ST_AW_ACK);
		apb(A_DATA, 1'h1, 32'h3c);
		stretch <= 1'h1;
		step(8'h44, isq_pkg::ST_TX_ACK);
		stretch <= 1'h0;
		step(8'h64, isq_pkg::ST_RSTART);
		step(8'h44, isq_pkg::ST_AW_ACK);
		s = stops;
		step(8'h74, isq_pkg::ST_START);
		chk(32'(stops - s), 32'h1);
		stop_bus(1'h0);
		tb_sda <= 2'h1;
		repeat (20) @(posedge clk_i);
		tb_scl <= 2'h1;
		apb(A_IST, 1'h1, 32'h1);
		apb(A_CTL, 1'h1, 32'h64);
		repeat (300) @(negedge clk_i);
		chk({30'h0, sda_oe_o}, 32'h0);
		@(posedge clk_i);
		tb_scl <= 2'h0;
		repeat (20) @(posedge clk_i);
		tb_sda <= 2'h0;
		awaitf(isq_pkg::ST_START);
		stop_bus(1'h0);
		apb(A_DATA, 1'h1, 32'ha5);
		step(8'h64, isq_pkg::ST_START);
		step(8'h44, isq_pkg::ST_AR_ACK);
		step(8'h44, isq_pkg::ST_RX_ACK);
		apb(A_DATA, 1'h0, 32'h0);
		chk(rdat, 32'hff);
		step(8'h40, isq_pkg::ST_RX_NAK);
		stop_bus(1'h0);
		// Foreign start inside a byte of ones
		apb(A_DATA, 1'h1, 32'ha4);
		step(8'h64, isq_pkg::ST_START);
		step(8'h44, isq_pkg::ST_AW_ACK);
		apb(A_DATA, 1'h1, 32'hff);
		apb(A_IST, 1'h1, 32'h1);
		apb(A_CTL, 1'h1, 32'h44);
		n = 0;
		while (scl_pin_i[0] !== 1'h1 && n < 4000) begin
			@(posedge clk_i);
			n++;
		end
		bound(n);
		tb_sda <= 2'h1;
		awaitf(isq_pkg::ST_BERR);
		apb(A_IST, 1'h0, 32'h0);
		chk(rdat & 32'h5, 32'h5);
		tb_sda <= 2'h0;
		repeat (20) @(posedge clk_i);
		s = stops;
		apb(A_CTL, 1'h1, 32'h54);
		apb(A_CTL, 1'h0, 32'h0);
		chk(rdat, 32'h44);
		apb(A_STAT, 1'h0, 32'h0);
		chk(rdat, 32'hf8);
		chk(32'(stops - s), 32'h0);
		chk({28'h0, scl_oe_o, sda_oe_o}, 32'h0);
		sel <= 1'h1;
		apb(A_DATA, 1'h1, 32'ha4);
		step(8'h65, isq_pkg::ST_START);
		chk({30'h0, scl_oe_o}, 32'h2);
		stop_bus(1'h1);
		// Reset in mid-run
		@(posedge clk_i);
		reset_n_i <= 1'h0;
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'h1;
		chk({28'h0, scl_oe_o, sda_oe_o}, 32'h0);
		apb(A_CTL, 1'h0, 32'h0);
		chk(rdat, 32'h0);
		apb(A_RATE, 1'h0, 32'h0);
		chk(rdat, 32'h10);
		end_sim();
	end
endmodule
`default_nettype wire
